// File: reset_cause_params.svh
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH

// register addresses on the device address bus
`define RCF_ADDR        16'h1800
`define DFR_ADDR        16'h1801

// reset_cause_flags bit positions
`define RCF_POR_BIT     7
`define RCF_PIN_BIT     6
`define RCF_WDOG_BIT    5
`define RCF_OPC_BIT     4
`define RCF_ADR_BIT     3
`define RCF_LVD_BIT     1
`define RCF_IMPL_MASK   8'hFA
`define RCF_POR_VALUE   8'h82
`define RCF_LVD_VALUE   8'h02

// debug_forced_reset_ctrl bit position and read value
`define DFR_FORCE_BIT   0
`define DFR_READ_VALUE  8'h00

// cycles the system reset output is held
`define HOLD_CYCLES     6'h20
`define HOLD_ONE        6'h01

// synchroniser reset pattern {mode pin, reset pin_n, lvd trip, por}
`define SYNC_RESET      4'hC

`endif

// File: reset_cause_pkg.sv
package reset_cause_pkg;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        from_debug;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } reg_access_t;

  typedef struct packed {
    logic low_voltage_reset_enable;
    logic watchdog_enable_setting;
    logic stop_allow_setting;
    logic background_mode_allow;
    logic watchdog_window_select;
  } sys_settings_t;

  typedef struct packed {
    logic wdog_timeout;
    logic wdog_late_window;
    logic bad_opcode;
    logic stop_exec;
    logic enter_background_instruction_exec;
    logic bad_address;
  } core_events_t;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_HOLD
  } seq_state_t;

endpackage

// File: pin_sync.sv
`include "reset_cause_params.svh"

module pin_sync (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // raw and synchronised levels
  input  wire logic [3:0] raw_i,
  output logic      [3:0] sync_o
);

  logic [3:0] stage1_reg;
  logic [3:0] stage2_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      stage1_reg <= `SYNC_RESET;
      stage2_reg <= `SYNC_RESET;
    end else begin
      stage1_reg <= raw_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule

// File: reset_cause_ctrl.sv
// Notes on behaviour
// - read-only register shows which source caused the latest reset
// - debug-forced reset leaves every cause flag cleared
// - any write to cause register restarts watchdog; flags unchanged except after an early windowed write
// - power-on sets bits 7 and 1, clears the rest
// - enabled low-voltage trip resets, sets bit 1, bit 7 unchanged
// - other resets clear bits 7,1; set active bits 6..3, clear others
// - bit 6 marks reset from low level on external reset pin
// - bit 5 marks watchdog timeout; ignored when watchdog disabled
// - bit 4 marks bad opcode, disallowed stop or background instruction
// - bit 3 marks access to unimplemented data or code address
// - debug-force register reads 0x00 and ignores program writes
// - debug write of 1 to bit 0 forces full device reset
// - windowed watchdog: cause-register write before last quarter resets
`include "reset_cause_params.svh"

module reset_cause_ctrl (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          srst_i,
  // register access from cpu or serial debug
  input  wire reset_cause_pkg::reg_access_t  acc_i,
  output logic                        [7:0]  rd_data_o,
  // configuration and core events
  input  wire reset_cause_pkg::sys_settings_t set_i,
  input  wire reset_cause_pkg::core_events_t  evt_i,
  // pins and analog detectors
  input  wire logic                          por_i,
  input  wire logic                          lvd_trip_i,
  input  wire logic                          reset_pin_n_i,
  input  wire logic                          background_mode_select_pin_i,
  // system reset and mode
  output logic                               system_reset_o,
  output logic                               wdog_restart_o,
  output logic                               background_mode_o
);

  import reset_cause_pkg::*;

  function automatic logic addr_hit(input logic [15:0] a,
                                    input logic [15:0] target);
    addr_hit = (a == target);
  endfunction

  // flags for resets other than power-on and low voltage
  function automatic logic [7:0] other_flags(input logic pin,
                                             input logic wdog,
                                             input logic opc,
                                             input logic adr,
                                             input logic force_dbg);
    logic [7:0] f;
    f = 8'h00;
    f[`RCF_PIN_BIT]  = pin;
    f[`RCF_WDOG_BIT] = wdog;
    f[`RCF_OPC_BIT]  = opc;
    f[`RCF_ADR_BIT]  = adr;
    // a forced reset must not look like any other source
    if (force_dbg) begin
      f = 8'h00;
    end
    other_flags = f;
  endfunction

  // low voltage keeps the power-on mark and adds its own
  function automatic logic [7:0] lvd_flags(input logic [7:0] old);
    lvd_flags = (old & (8'h01 << `RCF_POR_BIT)) | `RCF_LVD_VALUE;
  endfunction

  logic [3:0] pins_sync;
  logic       por_s;
  logic       lvd_s;
  logic       pin_n_s;
  logic       mode_s;

  pin_sync u_sync (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .raw_i  ({background_mode_select_pin_i, reset_pin_n_i, lvd_trip_i,
              por_i}),
    .sync_o (pins_sync)
  );

  assign por_s   = pins_sync[0];
  assign lvd_s   = pins_sync[1];
  assign pin_n_s = pins_sync[2];
  assign mode_s  = pins_sync[3];

  seq_state_t state_reg;
  seq_state_t state_next;
  logic [5:0] hold_reg;
  logic [5:0] hold_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic       forced_reg;
  logic       forced_next;
  logic       bdm_reg;
  logic       bdm_next;
  logic       rst_out_reg;
  logic       rst_out_next;
  logic       restart_reg;
  logic       restart_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  logic       rcf_wr;
  logic       dfr_force;
  logic       src_pin;
  logic       src_wdog;
  logic       src_opc;
  logic       src_adr;
  logic       src_lvd;
  logic       other_any;

  always_comb begin
    rcf_wr    = acc_i.wr && addr_hit(acc_i.addr, `RCF_ADDR);
    // program writes never reach the force bit
    dfr_force = acc_i.wr && acc_i.from_debug
                && addr_hit(acc_i.addr, `DFR_ADDR)
                && acc_i.wdata[`DFR_FORCE_BIT];
    src_pin   = !pin_n_s;
    // early service write counts as a watchdog failure
    src_wdog  = set_i.watchdog_enable_setting
                && (evt_i.wdog_timeout
                    || (rcf_wr && set_i.watchdog_window_select
                        && !evt_i.wdog_late_window));
    src_opc   = evt_i.bad_opcode
                || (evt_i.stop_exec && !set_i.stop_allow_setting)
                || (evt_i.enter_background_instruction_exec
                    && !set_i.background_mode_allow);
    src_adr   = evt_i.bad_address;
    src_lvd   = lvd_s && set_i.low_voltage_reset_enable;
    other_any = src_pin || src_wdog || src_opc || src_adr || dfr_force;
  end

  always_comb begin
    state_next   = state_reg;
    hold_next    = hold_reg;
    flags_next   = flags_reg;
    forced_next  = forced_reg;
    bdm_next     = bdm_reg;
    rst_out_next = rst_out_reg;
    restart_next = rcf_wr;
    // reads of the force register and unmapped addresses give zero
    rdata_next   = `DFR_READ_VALUE;
    if (acc_i.rd && addr_hit(acc_i.addr, `RCF_ADDR)) begin
      rdata_next = flags_reg & `RCF_IMPL_MASK;
    end
    // priority: power-on, then low voltage, then the rest
    if (por_s) begin
      flags_next  = `RCF_POR_VALUE;
      forced_next = 1'b0;
    end else if (src_lvd) begin
      flags_next  = lvd_flags(flags_reg);
      forced_next = 1'b0;
    end else if (state_reg == ST_RUN && other_any) begin
      flags_next  = other_flags(src_pin, src_wdog, src_opc, src_adr,
                                dfr_force);
      forced_next = dfr_force;
    end
    // sources seen during the hold are dropped; por and lvd retrigger
    if (por_s || src_lvd || (state_reg == ST_RUN && other_any)) begin
      state_next   = ST_HOLD;
      hold_next    = `HOLD_CYCLES;
      rst_out_next = 1'b1;
    end else begin
      case (state_reg)
        ST_RUN: begin
          rst_out_next = 1'b0;
        end
        ST_HOLD: begin
          // reset pin held low keeps the device in reset
          if (src_pin) begin
            hold_next = `HOLD_CYCLES;
          end else if (hold_reg == `HOLD_ONE) begin
            state_next   = ST_RUN;
            rst_out_next = 1'b0;
            // after a forced reset the mode pin level at release picks user or debug mode; other resets give user mode
            bdm_next    = forced_reg ? !mode_s : 1'b0;
            forced_next = 1'b0;
          end else begin
            hold_next = hold_reg - `HOLD_ONE;
          end
        end
        default: begin
          state_next = ST_RUN;
        end
      endcase
    end
  end

  // srst_i counts as power-on, so the flags leave it at 0x82
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg   <= ST_HOLD;
      hold_reg    <= `HOLD_CYCLES;
      flags_reg   <= `RCF_POR_VALUE;
      forced_reg  <= 1'b0;
      bdm_reg     <= 1'b0;
      rst_out_reg <= 1'b1;
      restart_reg <= 1'b0;
      rdata_reg   <= 8'h00;
    end else begin
      state_reg   <= state_next;
      hold_reg    <= hold_next;
      flags_reg   <= flags_next;
      forced_reg  <= forced_next;
      bdm_reg     <= bdm_next;
      rst_out_reg <= rst_out_next;
      restart_reg <= restart_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rd_data_o         = rdata_reg;
  assign system_reset_o    = rst_out_reg;
  assign wdog_restart_o    = restart_reg;
  assign background_mode_o = bdm_reg;

endmodule

// File: rc_props_properties.sv
`include "reset_cause_params.svh"
module rc_props (
  // watched ports
  input wire logic                           mclk_i,
  input wire logic                           srst_i,
  input wire reset_cause_pkg::reg_access_t   acc_i,
  input wire reset_cause_pkg::sys_settings_t set_i,
  input wire reset_cause_pkg::core_events_t  evt_i,
  input wire logic                     [7:0] rd_data_o,
  input wire logic                           system_reset_o,
  input wire logic                           wdog_restart_o
);
  import reset_cause_pkg::*;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  AST_RESTART: assert property (acc_i.wr && acc_i.addr == `RCF_ADDR
    |=> wdog_restart_o) else $error("no watchdog restart");
  AST_DFR_READ: assert property (acc_i.rd && acc_i.addr == `DFR_ADDR
    |=> rd_data_o == `DFR_READ_VALUE) else $error("force reg read");
  AST_UNUSED: assert property (acc_i.rd
    |=> !rd_data_o[2] && !rd_data_o[0]) else $error("unused bit set");
  AST_FORCE: assert property (acc_i.wr && acc_i.from_debug
    && acc_i.addr == `DFR_ADDR && acc_i.wdata[0] && !system_reset_o
    |=> system_reset_o) else $error("no forced reset");
  AST_WDOG: assert property (evt_i.wdog_timeout && !system_reset_o
    && set_i.watchdog_enable_setting |=> system_reset_o)
    else $error("no watchdog reset");
  AST_OPC: assert property ((evt_i.bad_opcode || evt_i.stop_exec
    && !set_i.stop_allow_setting || evt_i.enter_background_instruction_exec
    && !set_i.background_mode_allow) && !system_reset_o |=> system_reset_o)
    else $error("no opcode reset");
  AST_ADR: assert property (evt_i.bad_address && !system_reset_o
    |=> system_reset_o) else $error("no address reset");
  AST_HOLD: assert property ($rose(system_reset_o)
    |-> system_reset_o[*8]) else $error("reset too short");
  AST_WINDOW: assert property (acc_i.wr && acc_i.addr == `RCF_ADDR
    && set_i.watchdog_window_select && set_i.watchdog_enable_setting
    && !evt_i.wdog_late_window && !system_reset_o |=> system_reset_o)
    else $error("no window reset");
endmodule
bind reset_cause_ctrl rc_props u_props (.mclk_i, .srst_i, .acc_i, .set_i,
  .evt_i, .rd_data_o, .system_reset_o, .wdog_restart_o);

// File: bus_host.sv
`include "reset_cause_params.svh"
module bus_host (
  // bus clock
  input  wire logic                    mclk_i,
  // access strobes and mode pin
  output reset_cause_pkg::reg_access_t acc_o,
  output logic                         mode_pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import reset_cause_pkg::*;
  initial begin
    acc_o = '0;
    mode_pin_o = 1'b1;
  end
  // released bus drops the rd and wr strobes and shows inverted from_debug, addr and data, never the last ones
  task automatic op(input logic r, w, d, input logic [15:0] a,
                    input logic [7:0] v);
    @(negedge mclk_i);
    acc_o = '{r, w, d, a, v};
    @(negedge mclk_i);
    acc_o = '{1'b0, 1'b0, ~d, ~a, ~v};
  endtask
  // mode pin set with the write and held through the reset
  task automatic force_rst(input logic user);
    mode_pin_o = user;
    op(1'b0, 1'b1, 1'b1, `DFR_ADDR, 8'h01);
  endtask
endmodule

// File: reset_cause_and_debug_force_reset_tb.sv
`include "reset_cause_params.svh"
module reset_cause_and_debug_force_reset_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import reset_cause_pkg::*;
  logic          mclk_i = 0, srst_i = 1, pin_n = 1, low_voltage_flag = 0, por = 0;
  logic          sysr, bgm, mode, wdr;
  reg_access_t   acc;
  sys_settings_t set = 5'h18;
  core_events_t  evt = 6'h10;
  logic    [7:0] rdat, q[$];
  int            failures = 0, n_compared = 0, seed = 32'h1ECDBF02, i;
  core_events_t  ev_tab[5] = '{6'h30, 6'h18, 6'h14, 6'h12, 6'h11};
  logic    [7:0] ex_tab[5] = '{8'h20, 8'h10, 8'h10, 8'h10, 8'h08};
  reset_cause_ctrl DUT (.mclk_i, .srst_i, .acc_i(acc), .rd_data_o(rdat),
    .set_i(set), .evt_i(evt), .por_i(por), .lvd_trip_i(low_voltage_flag),
    .reset_pin_n_i(pin_n), .background_mode_select_pin_i(mode),
    .system_reset_o(sysr), .wdog_restart_o(wdr), .background_mode_o(bgm));
  bus_host host (.mclk_i, .acc_o(acc), .mode_pin_o(mode));
  initial forever #25 mclk_i = ~mclk_i;
  task automatic chk(input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // read data stands one cycle, so it is taken just after its edge
  always @(posedge mclk_i) begin
    #1;
    if (acc.rd) chk(rdat, q.pop_front());
    if (acc.wr) chk({7'h00, wdr}, {7'h00, acc.addr == `RCF_ADDR});
  end
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    host.op(1'b1, 1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic settle;
    repeat (4) @(negedge mclk_i);
    for (i = 0; i < 300 && sysr === 1'b1; i++) @(negedge mclk_i);
    chk({7'h00, sysr}, 8'h00);
  endtask
  task automatic ev(input core_events_t e);
    @(negedge mclk_i);
    evt = e;
    @(negedge mclk_i);
    evt = 6'h10;
  endtask
  task automatic lvd_rst(input logic [7:0] e);
    low_voltage_flag = 1'b1;
    repeat (3) @(negedge mclk_i);
    low_voltage_flag = 1'b0;
    settle;
    rd(`RCF_ADDR, e);
  endtask
  initial begin
    repeat (20) @(negedge mclk_i);
    srst_i = 1'b0;
    settle;
    rd(`RCF_ADDR, `RCF_POR_VALUE);
    rd(`DFR_ADDR, `DFR_READ_VALUE);
    rd(16'h1802, 8'h00);
    host.op(1'b0, 1'b1, 1'b0, `RCF_ADDR, 8'($random(seed)));
    host.op(1'b0, 1'b1, 1'b0, `DFR_ADDR, 8'h01);
    chk({7'h00, sysr}, 8'h00);
    rd(`RCF_ADDR, `RCF_POR_VALUE);
    lvd_rst(`RCF_POR_VALUE);
    set = 5'h10;
    ev(6'h30);
    chk({7'h00, sysr}, 8'h00);
    set = 5'h18;
    for (int k = 0; k < 5; k++) begin
      ev(ev_tab[k]);
      settle;
      rd(`RCF_ADDR, ex_tab[k]);
    end
    pin_n = 1'b0;
    repeat (3) @(negedge mclk_i);
    pin_n = 1'b1;
    settle;
    rd(`RCF_ADDR, 8'h40);
    lvd_rst(`RCF_LVD_VALUE);
    for (int u = 0; u < 2; u++) begin
      host.force_rst(u[0]);
      settle;
      rd(`RCF_ADDR, 8'h00);
      chk({7'h00, bgm}, {7'h00, ~u[0]});
    end
    set = 5'h19;
    evt = 6'h00;
    host.op(1'b0, 1'b1, 1'b0, `RCF_ADDR, 8'h55);
    settle;
    rd(`RCF_ADDR, 8'h20);
    set = 5'h18;
    evt = 6'h10;
    por = 1'b1;
    repeat (3) @(negedge mclk_i);
    por = 1'b0;
    settle;
    rd(`RCF_ADDR, `RCF_POR_VALUE);
    repeat (3) @(negedge mclk_i);
    final_report;
  end
  initial begin
    repeat (5000) @(posedge mclk_i);
    failures++;
    final_report;
  end
endmodule
